//--- sport_pkg.sv
// Constants and types shared by the serial result output port
package sport_pkg;

   localparam int RES_W      = 16;
   localparam int FIFO_DEPTH = 32;
   localparam int APB_AW     = 12;

   // Register byte offsets
   localparam logic [11:0] CTRL_OFS   = 12'h000;
   localparam logic [11:0] STATUS_OFS = 12'h004;
   localparam logic [11:0] LAST_OFS   = 12'h008;
   localparam logic [11:0] FRAMES_OFS = 12'h00c;

   // Control register fields and reset values
   localparam int          CTRL_DIV_LSB = 0;
   localparam int          CTRL_DIV_W   = 8;
   localparam int          CTRL_EN_BIT  = 8;
   localparam logic [7:0]  DIV_RST      = 8'h04;
   localparam logic        EN_RST       = 1'b1;

   // Status register field positions
   localparam int ST_LEVEL_LSB = 0;
   localparam int ST_HELD_BIT  = 8;
   localparam int ST_STATE_LSB = 9;
   localparam int ST_EXT_BIT   = 16;
   localparam int ST_SER_BIT   = 17;

   // Pin positions on the shared data bus
   localparam int PIN_CLKSRC = 4;
   localparam int PIN_POL    = 5;
   localparam int PIN_INV    = 6;
   localparam int PIN_RDC    = 7;
   localparam int PIN_SERIAL_RESULT_OUT  = 8;
   localparam int PIN_SCLK   = 9;
   localparam int PIN_SYNC   = 10;
   localparam int PIN_RDERR  = 11;

   // Input-only pins in serial mode
   localparam logic [15:0] SER_IN_MASK = 16'h00f0;

   localparam logic [4:0] LAST_BIT = 5'h0f;
   localparam logic [4:0] BIT_SAT  = 5'h10;

   typedef enum logic [1:0] {
      st_idle = 2'b00,
      st_int  = 2'b01,
      st_ext  = 2'b10
   } port_state_t;

endpackage : sport_pkg

//--- fifo_if.sv
// Push and pop signals between the port logic and its result FIFO
`timescale 1ns/1ns
interface fifo_if #(
   parameter int W     = 16,
   parameter int LVL_W = 6
);
   logic             push_valid;
   logic             push_ready;
   logic [W-1:0]     push_data;
   logic             pop_valid;
   logic             pop_ready;
   logic [W-1:0]     pop_data;
   logic [LVL_W-1:0] level;

   modport store (input push_valid, push_data, pop_ready,
                  output push_ready, pop_valid, pop_data, level);
   modport user  (output push_valid, push_data, pop_ready,
                  input push_ready, pop_valid, pop_data, level);
endinterface : fifo_if

//--- result_fifo.sv
// Result FIFO with registered head word
`timescale 1ns/1ns
module result_fifo #(
   parameter int W     = 16,
   parameter int DEPTH = 32
) (
   input  wire logic mclk,
   input  wire logic nrst,
   fifo_if.store     f
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = AW + 1;

   logic [W-1:0]  mem [DEPTH];
   logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [CW-1:0] cnt_q, cnt_d;
   logic [W-1:0]  out_q, out_d;
   logic          out_valid_q, out_valid_d;
   logic          room_q, room_d;
   logic          push, take;

   always_comb begin
      push        = f.push_valid & room_q;
      take        = (cnt_q != '0) & (~out_valid_q | f.pop_ready);
      wr_d        = push ? AW'(wr_q + 1'b1) : wr_q;
      rd_d        = take ? AW'(rd_q + 1'b1) : rd_q;
      cnt_d       = CW'(cnt_q + CW'(push) - CW'(take));
      room_d      = (cnt_d != CW'(DEPTH));
      out_d       = take ? mem[rd_q] : out_q;
      out_valid_d = take | (out_valid_q & ~f.pop_ready);
   end

   always_ff @(posedge mclk) begin
      if (push) begin
         mem[wr_q] <= f.push_data;
      end
      out_q <= out_d;
      if (!nrst) begin
         wr_q        <= '0;
         rd_q        <= '0;
         cnt_q       <= '0;
         out_valid_q <= 1'b0;
         room_q      <= 1'b0;
      end else begin
         wr_q        <= wr_d;
         rd_q        <= rd_d;
         cnt_q       <= cnt_d;
         out_valid_q <= out_valid_d;
         room_q      <= room_d;
      end
   end

   assign f.push_ready = room_q;
   assign f.pop_valid  = out_valid_q;
   assign f.pop_data   = out_q;
   assign f.level      = $bits(f.level)'(cnt_q + CW'(out_valid_q));

endmodule : result_fifo

//--- serial_port.sv
// Serial or parallel result output port with APB control
// Notes on behaviour
// - Select low: shared pins are parallel data bits 4 to 11.
// - Clock invert input inverts serial clock sense, master and slave.
// - External clock: read-mode pin is a daisy-chain data input.
// - Chain input level reaches serial output 16 clock periods after read start.
// - Internal clock: read-mode pin selects the read mode.
// - Read mode high: result shifted out while conversion runs.
// - Read mode low: result shifted out only after conversion completes.
// - Serial output carries the stored result, synchronised to serial clock.
// - Result leaves the shift register most significant bit first.
// - Result coding follows the output coding select input.
// - Internal clock: each output bit stable on both clock edges.
// - External clock, no invert: change on rising, host samples falling.
// - External clock, invert: change on falling, host samples rising.
// - Coding high gives straight binary; low inverts MSB for two's complement.
// - Clock source low drives internal clock out; high follows external clock.
// - Output bus enabled only while chip select and read are both low.
// - Internal clock: frame marker active while output valid, polarity pin-set.
//
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/1ns
module serial_port
   import sport_pkg::*;
#(
   parameter int DEPTH = sport_pkg::FIFO_DEPTH
) (
   input  wire logic                          mclk,
   input  wire logic                          nrst,
   input  wire logic [sport_pkg::APB_AW-1:0]  paddr,
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [31:0]                   pwdata,
   output logic      [31:0]                   prdata,
   output logic                               pready,
   output logic                               pslverr,
   input  wire logic [sport_pkg::RES_W-1:0]   result_data,
   input  wire logic                          result_valid,
   output logic                               result_ready,
   input  wire logic                          busy,
   input  wire logic                          serial_parallel_select,
   input  wire logic                          output_coding_select,
   input  wire logic                          cs_n,
   input  wire logic                          rd_n,
   input  wire logic [15:0]                   data_in,
   output logic      [15:0]                   data_out,
   output logic      [15:0]                   data_oe_n
);
   import sport_pkg::*;

   localparam int LVL_W = $clog2(DEPTH + 2);

   fifo_if #(.W(RES_W), .LVL_W(LVL_W)) fq ();

   result_fifo #(.W(RES_W), .DEPTH(DEPTH)) u_fifo (
      .mclk (mclk),
      .nrst (nrst),
      .f    (fq.store)
   );

   assign fq.push_valid = result_valid;
   assign fq.push_data  = result_data;
   assign result_ready  = fq.push_ready;

   // Pin synchronisers
   logic [19:0] sync1_q, sync2_q;
   logic [19:0] pins_raw;

   assign pins_raw = {serial_parallel_select, output_coding_select, cs_n, rd_n, data_in};

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         sync1_q <= 20'h3_0000;
         sync2_q <= 20'h3_0000;
      end else begin
         sync1_q <= pins_raw;
         sync2_q <= sync1_q;
      end
   end

   logic        s_ser, s_coding, s_cs_n, s_rd_n;
   logic [15:0] s_din;

   assign s_ser    = sync2_q[19];
   assign s_coding = sync2_q[18];
   assign s_cs_n   = sync2_q[17];
   assign s_rd_n   = sync2_q[16];
   assign s_din    = sync2_q[15:0];

   // Serial-mode controls, masked in parallel mode
   logic ext, inv, pol, read_mode_or_chain_in, bus_en;

   assign ext      = s_ser & s_din[PIN_CLKSRC];
   assign inv      = s_ser & s_din[PIN_INV];
   assign pol      = s_ser & s_din[PIN_POL];
   assign read_mode_or_chain_in = s_ser & s_din[PIN_RDC];
   assign bus_en   = ~s_cs_n & ~s_rd_n;

   // Port state
   port_state_t st_q, st_d;
   logic [RES_W-1:0] sh_q, sh_d;
   logic             held_q, held_d;
   logic [4:0]       bits_q, bits_d;
   logic [7:0]       div_q, div_d;
   logic [1:0]       qtr_q, qtr_d;
   logic             sclk_q, sclk_d;
   logic             serial_result_out_q, serial_result_out_d;
   logic             frame_q, frame_d;
   logic             rderr_q, rderr_d;
   logic             en_q, en_d;
   logic             busy_q, busy_d;
   logic             ext_clk_q, ext_clk_d;
   logic [RES_W-1:0] last_q, last_d;
   logic [15:0]      frames_q, frames_d;
   logic [15:0]      dout_q, dout_d;
   logic [15:0]      oe_n_q, oe_n_d;
   logic             pop;

   // Control registers
   logic [7:0]  ctrl_div_q, ctrl_div_d;
   logic        ctrl_en_q, ctrl_en_d;

   logic ext_rise, ext_fall, ext_active, tick, conv_end, rd_allowed;

   always_comb begin
      ext_rise   = s_din[PIN_SCLK] & ~ext_clk_q;
      ext_fall   = ~s_din[PIN_SCLK] & ext_clk_q;
      ext_active = inv ? ext_fall : ext_rise;
      tick       = (div_q == ctrl_div_q);
      conv_end   = busy_q & ~busy;
      rd_allowed = read_mode_or_chain_in ? busy : ~busy;

      st_d      = st_q;
      sh_d      = sh_q;
      held_d    = held_q;
      bits_d    = bits_q;
      div_d     = div_q;
      qtr_d     = qtr_q;
      sclk_d    = sclk_q;
      serial_result_out_d   = serial_result_out_q;
      frame_d   = frame_q;
      rderr_d   = 1'b0;
      en_d      = bus_en;
      busy_d    = busy;
      ext_clk_d = s_din[PIN_SCLK];
      last_d    = last_q;
      frames_d  = frames_q;
      pop       = 1'b0;

      case (st_q)
         st_idle: begin
            sclk_d  = 1'b0;
            frame_d = 1'b0;
            if (!held_q && fq.pop_valid) begin
               pop    = 1'b1;
               held_d = 1'b1;
               // Coding chosen at load time
               sh_d   = {fq.pop_data[RES_W-1] ^ ~s_coding,
                         fq.pop_data[RES_W-2:0]};
               last_d = {fq.pop_data[RES_W-1] ^ ~s_coding,
                         fq.pop_data[RES_W-2:0]};
            end else if (held_q && !s_ser) begin
               // Parallel word consumed when the read ends
               if (en_q && !bus_en) begin
                  held_d   = 1'b0;
                  frames_d = 16'(frames_q + 16'h0001);
               end
            end else if (held_q && ctrl_en_q && bus_en && ext) begin
               st_d    = st_ext;
               bits_d  = '0;
               serial_result_out_d = sh_q[RES_W-1];
            end else if (held_q && ctrl_en_q && bus_en && rd_allowed) begin
               st_d    = st_int;
               bits_d  = '0;
               div_d   = '0;
               qtr_d   = '0;
               serial_result_out_d = sh_q[RES_W-1];
               frame_d = 1'b1;
            end
         end
         st_int: begin
            div_d = tick ? 8'h00 : 8'(div_q + 8'h01);
            if (tick) begin
               qtr_d = 2'(qtr_q + 2'b01);
               if (qtr_q == 2'b00) begin
                  sclk_d = 1'b1;
               end else if (qtr_q == 2'b10) begin
                  sclk_d = 1'b0;
               end else if (qtr_q == 2'b11) begin
                  // Bit changes mid-low, away from both edges
                  if (bits_q == LAST_BIT) begin
                     st_d     = st_idle;
                     held_d   = 1'b0;
                     frame_d  = 1'b0;
                     frames_d = 16'(frames_q + 16'h0001);
                  end else begin
                     sh_d    = {sh_q[RES_W-2:0], 1'b0};
                     serial_result_out_d = sh_q[RES_W-2];
                     bits_d  = 5'(bits_q + 5'h01);
                  end
               end
            end
         end
         st_ext: begin
            if (ext_active) begin
               // Chain input follows the result after 16 shifts
               sh_d    = {sh_q[RES_W-2:0], read_mode_or_chain_in};
               serial_result_out_d = sh_q[RES_W-2];
               bits_d  = (bits_q == BIT_SAT) ? BIT_SAT : 5'(bits_q + 5'h01);
            end
            if (conv_end && bits_q != BIT_SAT) begin
               rderr_d = 1'b1;
            end
            if (!bus_en || !ext) begin
               st_d     = st_idle;
               held_d   = 1'b0;
               frames_d = 16'(frames_q + 16'h0001);
            end
         end
         default: begin
            st_d = st_idle;
         end
      endcase
   end

   assign fq.pop_ready = pop;

   // Pin drive
   always_comb begin
      dout_d = '0;
      oe_n_d = {16{~bus_en}};
      if (!s_ser) begin
         dout_d = held_q ? sh_q : 16'h0000;
      end else begin
         oe_n_d                 = {16{~bus_en}} | SER_IN_MASK;
         // Next values keep slave-clock latency within half a link period
         dout_d[PIN_SERIAL_RESULT_OUT]      = serial_result_out_d;
         dout_d[PIN_SCLK]       = sclk_d ^ inv;
         oe_n_d[PIN_SCLK]       = ~bus_en | ext;
         dout_d[PIN_SYNC]       = ext ? pol : (frame_d ^ pol);
         dout_d[PIN_RDERR]      = rderr_q;
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         st_q      <= st_idle;
         sh_q      <= '0;
         held_q    <= 1'b0;
         bits_q    <= '0;
         div_q     <= '0;
         qtr_q     <= '0;
         sclk_q    <= 1'b0;
         serial_result_out_q   <= 1'b0;
         frame_q   <= 1'b0;
         rderr_q   <= 1'b0;
         en_q      <= 1'b0;
         busy_q    <= 1'b0;
         ext_clk_q <= 1'b0;
         last_q    <= '0;
         frames_q  <= '0;
         dout_q    <= '0;
         oe_n_q    <= 16'hffff;
      end else begin
         st_q      <= st_d;
         sh_q      <= sh_d;
         held_q    <= held_d;
         bits_q    <= bits_d;
         div_q     <= div_d;
         qtr_q     <= qtr_d;
         sclk_q    <= sclk_d;
         serial_result_out_q   <= serial_result_out_d;
         frame_q   <= frame_d;
         rderr_q   <= rderr_d;
         en_q      <= en_d;
         busy_q    <= busy_d;
         ext_clk_q <= ext_clk_d;
         last_q    <= last_d;
         frames_q  <= frames_d;
         dout_q    <= dout_d;
         oe_n_q    <= oe_n_d;
      end
   end

   assign data_out  = dout_q;
   assign data_oe_n = oe_n_q;

   // APB slave, one wait state
   logic        pready_q, pready_d;
   logic        pslverr_q, pslverr_d;
   logic [31:0] prdata_q, prdata_d;
   logic        acc, wr_hit;

   always_comb begin
      acc        = psel & penable & ~pready_q;
      wr_hit     = psel & penable & pready_q & pwrite;
      pready_d   = acc;
      pslverr_d  = 1'b0;
      prdata_d   = '0;
      ctrl_div_d = ctrl_div_q;
      ctrl_en_d  = ctrl_en_q;
      if (paddr == CTRL_OFS) begin
         prdata_d[CTRL_DIV_LSB +: CTRL_DIV_W] = ctrl_div_q;
         prdata_d[CTRL_EN_BIT]                = ctrl_en_q;
         if (wr_hit) begin
            ctrl_div_d = pwdata[CTRL_DIV_LSB +: CTRL_DIV_W];
            ctrl_en_d  = pwdata[CTRL_EN_BIT];
         end
      end else if (paddr == STATUS_OFS) begin
         prdata_d[ST_LEVEL_LSB +: LVL_W] = fq.level;
         prdata_d[ST_HELD_BIT]           = held_q;
         prdata_d[ST_STATE_LSB +: 2]     = st_q;
         prdata_d[ST_EXT_BIT]            = ext;
         prdata_d[ST_SER_BIT]            = s_ser;
      end else if (paddr == LAST_OFS) begin
         prdata_d[RES_W-1:0] = last_q;
      end else if (paddr == FRAMES_OFS) begin
         prdata_d[15:0] = frames_q;
      end else begin
         pslverr_d = acc;
      end
      if (!acc) begin
         prdata_d  = '0;
         pslverr_d = 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         pready_q   <= 1'b0;
         pslverr_q  <= 1'b0;
         prdata_q   <= '0;
         ctrl_div_q <= DIV_RST;
         ctrl_en_q  <= EN_RST;
      end else begin
         pready_q   <= pready_d;
         pslverr_q  <= pslverr_d;
         prdata_q   <= prdata_d;
         ctrl_div_q <= ctrl_div_d;
         ctrl_en_q  <= ctrl_en_d;
      end
   end

   assign pready  = pready_q;
   assign pslverr = pslverr_q;
   assign prdata  = prdata_q;

endmodule : serial_port

//--- serial_port_sva.sv
// Concurrent checks on the pins and bus of the serial result port
`timescale 1ns/1ns
module serial_port_sva
   import sport_pkg::*;
#(
   parameter int DEPTH = 32
) (
   input wire logic        mclk,
   input wire logic        nrst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        serial_parallel_select,
   input wire logic        cs_n,
   input wire logic        rd_n,
   input wire logic [15:0] data_in,
   input wire logic [15:0] data_out,
   input wire logic [15:0] data_oe_n
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);

   bus_off_a: assert property ((cs_n | rd_n)[*5] |-> data_oe_n == 16'hffff)
      else $error("Pins driven while bus disabled");
   ser_in_a: assert property (serial_parallel_select[*5] |-> &data_oe_n[7:4])
      else $error("Serial input pins driven");
   par_out_a: assert property ((!serial_parallel_select && !cs_n && !rd_n)[*5]
      |-> data_oe_n[8:6] == 3'b000) else $error("Parallel bits 6 to 8 not driven");
   ext_clk_a: assert property ((serial_parallel_select && data_in[PIN_CLKSRC])[*5]
      |-> data_oe_n[PIN_SCLK]) else $error("Clock pin driven in external mode");
   int_clk_a: assert property ((serial_parallel_select && !data_in[PIN_CLKSRC]
      && !cs_n && !rd_n)[*5] |-> !data_oe_n[PIN_SCLK]) else $error("Clock pin not driven");
   sync_idle_a: assert property ((serial_parallel_select && data_in[PIN_CLKSRC]
      && $stable(data_in[PIN_POL]))[*5] |-> data_out[PIN_SYNC] == data_in[PIN_POL])
      else $error("Frame marker active in external mode");
   bit_stable_a: assert property ((serial_parallel_select && !data_in[PIN_CLKSRC])[*5]
      ##0 $changed(data_out[PIN_SCLK]) |-> $stable(data_out[PIN_SERIAL_RESULT_OUT]))
      else $error("Serial bit changed on a clock edge");
   one_wait_a: assert property (psel && $rose(penable) |=> pready)
      else $error("Ready not in second access cycle");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("Ready longer than one cycle");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("Error without ready");
   rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
      else $error("Read data outside answer");
endmodule : serial_port_sva

bind serial_port serial_port_sva #(.DEPTH(DEPTH)) serial_port_sva_i (
   .mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .serial_parallel_select(serial_parallel_select),
   .cs_n(cs_n), .rd_n(rd_n), .data_in(data_in), .data_out(data_out),
   .data_oe_n(data_oe_n));

//--- serial_host.sv
// Host model: captures serial results and makes the slave clock
`timescale 1ns/1ns
module serial_host (
   input  wire logic ext_mode,
   input  wire logic inv,
   input  wire logic pol,
   input  wire logic sclk_pin,
   input  wire logic serial_result_out,
   input  wire logic marker,
   output logic      sclk_out,
   output logic      chain_out
);
   logic [31:0] got = 32'h0000_0000;
   int          cnt = 0;

   initial begin
      sclk_out  = 1'b0;
      chain_out = 1'b0;
   end

   // Device clock: one bit per active edge while the marker is active
   always @(sclk_pin) begin
      if (!ext_mode && (marker ^ pol) && (sclk_pin ^ inv)) begin
         got = {got[30:0], serial_result_out};
         cnt++;
      end
   end

   task clear();
      got = 32'h0000_0000;
      cnt = 0;
   endtask : clear

   task park();
      sclk_out <= inv;
   endtask : park

   // Idle at the sampling level; chain bits set ahead of each active edge
   task run_ext(input logic [15:0] chain);
      for (int i = 0; i < 32; i++) begin
         got = {got[30:0], serial_result_out};
         cnt++;
         chain_out <= (i < 16) ? chain[15 - i] : !chain_out;
         if (i == 31) break;
         #80 sclk_out <= !inv;
         #80 sclk_out <= inv;
      end
   endtask : run_ext
endmodule : serial_host

//--- serial_port_bench.sv
// Self-checking bench for the serial result output port
`timescale 1ns/1ns
module serial_port_bench;
   import sport_pkg::*;
   logic        mclk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata;
   logic        pready, pslverr, result_ready, sclk_h, chain_h;
   logic [15:0] result_data = 16'h0000, data_in, data_out, data_oe_n;
   logic        result_valid = 1'b0, busy = 1'b0, serial_parallel_select = 1'b0;
   logic        output_coding_select = 1'b1, cs_n = 1'b1, rd_n = 1'b1;
   logic        ext = 1'b0, pol = 1'b0, inv = 1'b0, rdc = 1'b0;
   int          error_cnt = 0, compares = 0;

   // Wire level of the shared pins from both parties
   assign data_in = (data_out & ~data_oe_n) |
      ({6'h00, sclk_h, 1'b0, ext ? chain_h : rdc, inv, pol, ext, 4'h0} & data_oe_n);

   always #10 mclk = ~mclk;

   serial_port #(.DEPTH(32)) serial_port_i (.mclk(mclk), .nrst(nrst), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .result_data(result_data),
      .result_valid(result_valid), .result_ready(result_ready), .busy(busy),
      .serial_parallel_select(serial_parallel_select),
      .output_coding_select(output_coding_select), .cs_n(cs_n), .rd_n(rd_n),
      .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n));

   serial_host serial_host_i (.ext_mode(ext), .inv(inv), .pol(pol),
      .sclk_pin(data_in[PIN_SCLK]), .serial_result_out(data_in[PIN_SERIAL_RESULT_OUT]), .marker(data_in[PIN_SYNC]),
      .sclk_out(sclk_h), .chain_out(chain_h));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // Idle cycle between transfers
      @(posedge mclk);
   endtask : apb

   task automatic push(input logic [15:0] w);
      result_data  <= w;
      result_valid <= 1'b1;
      for (int j = 0; j < 50; j++) begin
         @(posedge mclk);
         if (result_ready === 1'b1) break;
      end
      result_valid <= 1'b0;
   endtask : push

   task automatic t_regs();
      logic [31:0] d;
      logic        e;
      apb(1'b0, CTRL_OFS, 32'h0000_0000, d, e);
      chk(d, 32'h0000_0104);
      apb(1'b1, CTRL_OFS, 32'h0000_0003, d, e);
      apb(1'b0, CTRL_OFS, 32'h0000_0000, d, e);
      chk(d, 32'h0000_0003);
      apb(1'b1, CTRL_OFS, 32'h0000_0104, d, e);
      apb(1'b0, 12'h010, 32'h0000_0000, d, e);
      chk({d[30:0], e}, 32'h0000_0001);
   endtask : t_regs

   // Fill the FIFO until refused, drain it through parallel reads
   task automatic t_parallel();
      logic [31:0] d;
      logic        e;
      logic [15:0] ex;
      int          n;
      n = 0;
      output_coding_select <= 1'b0;
      inv <= 1'b1;
      rdc <= 1'b1;
      repeat (4) @(posedge mclk);
      result_valid <= 1'b1;
      for (int i = 0; i < 40; i++) begin
         @(posedge mclk);
         if (result_ready === 1'b1) begin
            n++;
            result_data <= result_data + 16'h0101;
         end
      end
      result_valid <= 1'b0;
      apb(1'b0, STATUS_OFS, 32'h0000_0000, d, e);
      chk(32'(d[5:0]) + 32'(d[8]), 32'(n));
      for (int k = 0; k < n; k++) begin
         ex = (16'(k) * 16'h0101) ^ 16'h8000;
         cs_n <= 1'b0;
         rd_n <= 1'b0;
         repeat (6) @(posedge mclk);
         for (int j = 0; j < 20 && data_out !== ex; j++) @(posedge mclk);
         chk(32'(data_out), 32'(ex));
         cs_n <= 1'b1;
         rd_n <= 1'b1;
         repeat (8) @(posedge mclk);
      end
      apb(1'b0, STATUS_OFS, 32'h0000_0000, d, e);
      chk(32'({d[8], d[5:0]}), 32'h0000_0000);
   endtask : t_parallel

   // Device clock frame; busy first driven to the level at which no read may start
   task automatic t_int(input logic [15:0] w, input logic c, iv, pv, rv);
      logic [31:0] d;
      logic        e;
      logic [15:0] cw;
      cw = w ^ {~c, 15'h0000};
      serial_parallel_select <= 1'b1;
      output_coding_select <= c;
      inv  <= iv;
      pol  <= pv;
      rdc  <= rv;
      busy <= ~rv;
      cs_n <= 1'b0;
      rd_n <= 1'b0;
      repeat (6) @(posedge mclk);
      serial_host_i.clear();
      push(w);
      repeat (40) @(posedge mclk);
      chk(32'(serial_host_i.cnt), 32'h0000_0000);
      busy <= rv;
      for (int j = 0; j < 600 && serial_host_i.cnt < 16; j++) @(posedge mclk);
      repeat (30) @(posedge mclk);
      chk(serial_host_i.got, {16'h0000, cw});
      chk(32'(serial_host_i.cnt), 32'h0000_0010);
      chk(32'(data_out[10:9]), 32'({pv, iv}));
      apb(1'b0, LAST_OFS, 32'h0000_0000, d, e);
      chk(d, {16'h0000, cw});
      busy <= 1'b0;
   endtask : t_int

   // Slave clock frame with chained data behind the result
   task automatic t_ext(input logic [15:0] w, ch, input logic iv);
      logic [31:0] d;
      logic        e;
      ext  <= 1'b1;
      inv  <= iv;
      output_coding_select <= 1'b1;
      cs_n <= 1'b1;
      rd_n <= 1'b1;
      @(posedge mclk);
      serial_host_i.park();
      push(w);
      repeat (10) @(posedge mclk);
      apb(1'b0, STATUS_OFS, 32'h0000_0000, d, e);
      chk(32'(d[17:16]), 32'h0000_0003);
      cs_n <= 1'b0;
      rd_n <= 1'b0;
      repeat (10) @(posedge mclk);
      serial_host_i.clear();
      serial_host_i.run_ext(ch);
      @(posedge mclk);
      chk(serial_host_i.got, {w, ch});
      cs_n <= 1'b1;
      rd_n <= 1'b1;
      repeat (10) @(posedge mclk);
   endtask : t_ext

   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : complete_run

   initial begin
      #400_000;
      error_cnt++;
      complete_run();
   end

   initial begin
      logic [31:0] d;
      logic        e;
      repeat (5) @(posedge mclk);
      nrst <= 1'b1;
      repeat (3) @(posedge mclk);
      t_regs();
      t_parallel();
      t_int(16'ha5c3, 1'b1, 1'b0, 1'b0, 1'b0);
      t_int(16'h3c96, 1'b0, 1'b1, 1'b1, 1'b1);
      t_ext(16'hc35a, 16'h6d29, 1'b0);
      t_ext(16'h1e87, 16'hb4f1, 1'b1);
      // 34 parallel words, two internal and two external frames
      apb(1'b0, FRAMES_OFS, 32'h0000_0000, d, e);
      chk(d, 32'h0000_0026);
      complete_run();
   end
endmodule : serial_port_bench
